/* common/gpio_line_pkg.sv */
/*
  Shared constants of the per-line parallel I/O control and status block:
  register offsets, reset values and bus widths.
  Assumes a plain single-cycle register port with byte addresses and 32-bit data.
*/
package gpio_line_pkg;

  // ==========================================================================
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_OUT_ENABLE        = 8'h00;
  localparam logic [7:0] OFS_OUT_DISABLE       = 8'h04;
  localparam logic [7:0] OFS_OUT_ENABLE_STATUS = 8'h08;
  localparam logic [7:0] OFS_FILT_ENABLE       = 8'h0C;
  localparam logic [7:0] OFS_FILT_DISABLE      = 8'h10;
  localparam logic [7:0] OFS_FILT_STATUS       = 8'h14;
  localparam logic [7:0] OFS_DRIVE_SET         = 8'h18;
  localparam logic [7:0] OFS_DRIVE_CLEAR       = 8'h1C;
  localparam logic [7:0] OFS_DRIVE_STATUS      = 8'h20;
  localparam logic [7:0] OFS_PIN_LEVEL         = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE        = 8'h28;
  localparam logic [7:0] OFS_IRQ_DISABLE       = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK          = 8'h30;
  localparam logic [7:0] OFS_CHANGE_STATUS     = 8'h34;
  localparam logic [7:0] OFS_DIRECT_ENABLE     = 8'h38;
  localparam logic [7:0] OFS_DIRECT_DISABLE    = 8'h3C;
  localparam logic [7:0] OFS_DIRECT_STATUS     = 8'h40;
  localparam logic [7:0] OFS_CHANGE_CLEAR      = 8'h44;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_OUT_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_FILTER     = 32'h0000_0000;
  localparam logic [31:0] RST_DRIVE      = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK   = 32'h0000_0000;
  localparam logic [31:0] RST_DIRECT     = 32'h0000_0000;
  localparam logic [31:0] RST_CHANGE     = 32'h0000_0000;
  localparam logic [31:0] RST_LEVEL      = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

  // ==========================================================================
  // Timing counts
  // Edges after reset before a pin level is trusted for change detection:
  // two synchroniser stages, the level register and the previous level.
  localparam int PRIME_EDGES = 4;

endpackage : gpio_line_pkg

/* hdl/gpio_line_control_status.sv */
/*
  Per-line control and status logic of a 32-line parallel I/O controller:
  output enable, glitch filter, drive value set/clear, pin readback and
  input-change interrupt. Change detection starts a few edges after reset.
  Assumes a single-cycle register master on the same clock, and pins that
  arrive asynchronously and are driven through an external tri-state pad.
*/
//
// Function
// - Every register holds one bit per line, bit n for line n, 32 lines.
// - Output status bit reads 1 when the line driver is on, else 0.
// - Writing 1 to filter enable turns that line's glitch filter on.
// - Writing 1 to filter disable turns that line's glitch filter off.
// - Filter status bit reads 1 while that line's filter is on.
// - Writing 1 to drive set makes that line's stored drive value 1.
// - Writing 1 to drive clear makes that line's stored drive value 0.
// - Drive status reads the value scheduled to be driven on each line.
// - Drive status is writable only for lines in direct-write mode.
// - Pin level status reports the actual level on each line.
// - Writing 1 to interrupt enable enables that line's change interrupt.
// - Writing 1 to interrupt disable disables that line's change interrupt.
// - Interrupt mask bit reads 1 while that line's change interrupt is enabled.
// - Change flag sets on any level change, holds until status read, a 1 written to change clear, or reset.
// - Writing 1 to output disable turns that line's driver off.
`timescale 1ns/1ps

module gpio_line_control_status #(
  parameter int LINES = 32
) (
  // Clock and reset
  input  wire logic                                i_clock,
  input  wire logic                                i_rst,
  // Register port
  input  wire logic [gpio_line_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [gpio_line_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                                i_wr,
  input  wire logic                                i_rd,
  output logic      [gpio_line_pkg::DATA_W-1:0]    o_rdata,
  // Interrupt
  output logic                                     o_irq,
  // I/O lines
  input  wire logic [LINES-1:0]                    i_line_in,
  output logic      [LINES-1:0]                    o_line_out,
  output logic      [LINES-1:0]                    o_line_oe_n
);

  // ==========================================================================
  // Helper functions

  // Write-one-to-set and write-one-to-clear share one update rule; a bit
  // named in both writes cannot occur since strobes never coincide.
  function automatic logic [LINES-1:0] apply_set_clear(
    input logic [LINES-1:0] cur,
    input logic [LINES-1:0] set_bits,
    input logic [LINES-1:0] clr_bits
  );
    apply_set_clear = (cur | set_bits) & ~clr_bits;
  endfunction : apply_set_clear

  // Register hit decode, used for the write strobes and the change status read.
  function automatic logic hit(
    input logic [gpio_line_pkg::ADDR_W-1:0] addr,
    input logic [gpio_line_pkg::ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  // Places line-wide data into the low bits of a bus word.
  function automatic logic [gpio_line_pkg::DATA_W-1:0] to_word(
    input logic [LINES-1:0] bits
  );
    logic [gpio_line_pkg::DATA_W-1:0] w;
    w = '0;
    w[LINES-1:0] = bits;
    to_word = w;
  endfunction : to_word

  // ==========================================================================
  // Register state
  logic [LINES-1:0] out_enable_r;
  logic [LINES-1:0] filter_on_r;
  logic [LINES-1:0] drive_r;
  logic [LINES-1:0] drive_nxt;
  logic [LINES-1:0] irq_mask_r;
  logic [LINES-1:0] direct_r;
  logic [LINES-1:0] change_r;
  logic [LINES-1:0] change_nxt;

  // Input path state
  logic [LINES-1:0] sync1_r;
  logic [LINES-1:0] sync2_r;
  logic [LINES-1:0] sync3_r;
  logic [LINES-1:0] level_r;
  logic [LINES-1:0] level_nxt;
  logic [LINES-1:0] level_prev_r;
  logic [2:0]       prime_cnt_r;
  logic             level_valid;

  // Write data seen as line bits.
  logic [LINES-1:0] wbits;
  assign wbits = i_wdata[LINES-1:0];

  // Decoded write strobes and the change status read strobe.
  logic wr_out_en;
  logic wr_out_dis;
  logic wr_filt_en;
  logic wr_filt_dis;
  logic wr_drv_set;
  logic wr_drv_clr;
  logic wr_drv_direct;
  logic wr_irq_en;
  logic wr_irq_dis;
  logic wr_dir_en;
  logic wr_dir_dis;
  logic wr_chg_clr;
  logic rd_chg;

  assign wr_out_en     = i_wr && hit(i_addr, gpio_line_pkg::OFS_OUT_ENABLE);
  assign wr_out_dis    = i_wr && hit(i_addr, gpio_line_pkg::OFS_OUT_DISABLE);
  assign wr_filt_en    = i_wr && hit(i_addr, gpio_line_pkg::OFS_FILT_ENABLE);
  assign wr_filt_dis   = i_wr && hit(i_addr, gpio_line_pkg::OFS_FILT_DISABLE);
  assign wr_drv_set    = i_wr && hit(i_addr, gpio_line_pkg::OFS_DRIVE_SET);
  assign wr_drv_clr    = i_wr && hit(i_addr, gpio_line_pkg::OFS_DRIVE_CLEAR);
  assign wr_drv_direct = i_wr && hit(i_addr, gpio_line_pkg::OFS_DRIVE_STATUS);
  assign wr_irq_en     = i_wr && hit(i_addr, gpio_line_pkg::OFS_IRQ_ENABLE);
  assign wr_irq_dis    = i_wr && hit(i_addr, gpio_line_pkg::OFS_IRQ_DISABLE);
  assign wr_dir_en     = i_wr && hit(i_addr, gpio_line_pkg::OFS_DIRECT_ENABLE);
  assign wr_dir_dis    = i_wr && hit(i_addr, gpio_line_pkg::OFS_DIRECT_DISABLE);
  assign wr_chg_clr    = i_wr && hit(i_addr, gpio_line_pkg::OFS_CHANGE_CLEAR);
  assign rd_chg        = i_rd && hit(i_addr, gpio_line_pkg::OFS_CHANGE_STATUS);

  // ==========================================================================
  // Output driver enable
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      out_enable_r <= gpio_line_pkg::RST_OUT_ENABLE;
    end else if (wr_out_en) begin
      out_enable_r <= apply_set_clear(out_enable_r, wbits, '0);
    end else if (wr_out_dis) begin
      out_enable_r <= apply_set_clear(out_enable_r, '0, wbits);
    end
  end

  // ==========================================================================
  // Glitch filter enable
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      filter_on_r <= gpio_line_pkg::RST_FILTER;
    end else if (wr_filt_en) begin
      filter_on_r <= apply_set_clear(filter_on_r, wbits, '0);
    end else if (wr_filt_dis) begin
      filter_on_r <= apply_set_clear(filter_on_r, '0, wbits);
    end
  end

  // ==========================================================================
  // Direct-write mode for the drive status register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      direct_r <= gpio_line_pkg::RST_DIRECT;
    end else if (wr_dir_en) begin
      direct_r <= apply_set_clear(direct_r, wbits, '0);
    end else if (wr_dir_dis) begin
      direct_r <= apply_set_clear(direct_r, '0, wbits);
    end
  end

  // ==========================================================================
  // Stored drive value
  always_comb begin
    drive_nxt = drive_r;
    if (wr_drv_set) begin
      drive_nxt = apply_set_clear(drive_r, wbits, '0);
    end else if (wr_drv_clr) begin
      drive_nxt = apply_set_clear(drive_r, '0, wbits);
    end else if (wr_drv_direct) begin
      // Lines outside direct-write mode keep their value.
      drive_nxt = (drive_r & ~direct_r) | (wbits & direct_r);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      drive_r <= gpio_line_pkg::RST_DRIVE;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  // ==========================================================================
  // Change interrupt mask
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_r <= gpio_line_pkg::RST_IRQ_MASK;
    end else if (wr_irq_en) begin
      irq_mask_r <= apply_set_clear(irq_mask_r, wbits, '0);
    end else if (wr_irq_dis) begin
      irq_mask_r <= apply_set_clear(irq_mask_r, '0, wbits);
    end
  end

  // ==========================================================================
  // Pin synchronisers and glitch filter
  // The first stage feeds only the second; filtering looks at stages two
  // and three, so a level must stand two samples before a filtered line
  // follows it. That costs one cycle of latency on filtered lines only.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= gpio_line_pkg::RST_LEVEL;
      sync2_r <= gpio_line_pkg::RST_LEVEL;
    end else begin
      sync1_r <= i_line_in;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================================
  // Filter history
  // Kept apart from the synchroniser so that nothing but the second stage
  // ever reads the first, whatever the filter settings.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync3_r <= gpio_line_pkg::RST_LEVEL;
    end else begin
      sync3_r <= sync2_r;
    end
  end

  always_comb begin
    level_nxt = level_r;
    for (int n = 0; n < LINES; n++) begin
      if (!filter_on_r[n]) begin
        level_nxt[n] = sync2_r[n];
      end else if (sync2_r[n] == sync3_r[n]) begin
        level_nxt[n] = sync2_r[n];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      level_r <= gpio_line_pkg::RST_LEVEL;
    end else begin
      level_r <= level_nxt;
    end
  end

  // ==========================================================================
  // Change detection
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      level_prev_r <= gpio_line_pkg::RST_LEVEL;
    end else begin
      level_prev_r <= level_r;
    end
  end

  // ==========================================================================
  // Start-up priming
  // The first edges after reset only fill the synchroniser and the previous
  // level, so a pin that rests high does not raise a false change at
  // start-up. The price is that a real change in those few edges is lost,
  // which is harmless since software cannot have enabled anything yet.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      prime_cnt_r <= '0;
    end else if (!level_valid) begin
      prime_cnt_r <= prime_cnt_r + 3'h1;
    end
  end

  assign level_valid = (prime_cnt_r == 3'(gpio_line_pkg::PRIME_EDGES));

  always_comb begin
    change_nxt = change_r;
    if (rd_chg) begin
      change_nxt = '0;
    end else if (wr_chg_clr) begin
      change_nxt = change_r & ~wbits;
    end
    // A change in the cycle of the clearing read or write is kept.
    if (level_valid) begin
      change_nxt = change_nxt | (level_r ^ level_prev_r);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      change_r <= gpio_line_pkg::RST_CHANGE;
    end else begin
      change_r <= change_nxt;
    end
  end

  // ==========================================================================
  // Interrupt request
  assign o_irq = |(change_r & irq_mask_r);

  // ==========================================================================
  // Pin drive
  assign o_line_out  = drive_r;
  assign o_line_oe_n = ~out_enable_r;

  // ==========================================================================
  // Read data
  // The change status returns its value before this read clears it.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= gpio_line_pkg::UNMAPPED_READ;
    end else if (i_rd) begin
      case (i_addr)
        gpio_line_pkg::OFS_OUT_ENABLE_STATUS: begin
          o_rdata <= to_word(out_enable_r);
        end
        gpio_line_pkg::OFS_FILT_STATUS: begin
          o_rdata <= to_word(filter_on_r);
        end
        gpio_line_pkg::OFS_DRIVE_STATUS: begin
          o_rdata <= to_word(drive_r);
        end
        gpio_line_pkg::OFS_PIN_LEVEL: begin
          o_rdata <= to_word(level_r);
        end
        gpio_line_pkg::OFS_IRQ_MASK: begin
          o_rdata <= to_word(irq_mask_r);
        end
        gpio_line_pkg::OFS_CHANGE_STATUS: begin
          o_rdata <= to_word(change_r);
        end
        gpio_line_pkg::OFS_DIRECT_STATUS: begin
          o_rdata <= to_word(direct_r);
        end
        default: begin
          o_rdata <= gpio_line_pkg::UNMAPPED_READ;
        end
      endcase
    end else begin
      o_rdata <= gpio_line_pkg::UNMAPPED_READ;
    end
  end

endmodule : gpio_line_control_status

/* tb/gpio_line_checker_assertions.sv */
/*
  Port checker for the line control block, bound to its top module.
  Assumes one clock, an active high reset and a read strobe never beside a write.
*/
`timescale 1ns/1ps
module gpio_line_checker #(
  parameter int LINES = 32
) (
  // Clock and reset
  input wire logic              i_clock,
  input wire logic              i_rst,
  // Register port
  input wire logic [7:0]        i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  // Interrupt and lines
  input wire logic              o_irq,
  input wire logic [LINES-1:0]  i_line_in,
  input wire logic [LINES-1:0]  o_line_out,
  input wire logic [LINES-1:0]  o_line_oe_n
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic w_oe_on  = i_wr && (i_addr == gpio_line_pkg::OFS_OUT_ENABLE);
  wire logic w_oe_off = i_wr && (i_addr == gpio_line_pkg::OFS_OUT_DISABLE);
  wire logic w_set    = i_wr && (i_addr == gpio_line_pkg::OFS_DRIVE_SET);
  wire logic w_clr    = i_wr && (i_addr == gpio_line_pkg::OFS_DRIVE_CLEAR);
  wire logic w_dir    = i_wr && (i_addr == gpio_line_pkg::OFS_DRIVE_STATUS);

  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  AST_OE_ON: assert property (w_oe_on |=> (o_line_oe_n & $past(i_wdata)) == 32'h0)
    else $error("output enable write did not drive the lines");
  AST_OE_OFF: assert property (w_oe_off |=> (~o_line_oe_n & $past(i_wdata)) == 32'h0)
    else $error("output disable write left a driver on");
  AST_OE_HOLD: assert property (!w_oe_on && !w_oe_off |=> $stable(o_line_oe_n))
    else $error("output enable changed without a write");
  AST_DRV_SET: assert property (w_set |=> (~o_line_out & $past(i_wdata)) == 32'h0)
    else $error("drive set write missed a line");
  AST_DRV_CLR: assert property (w_clr |=> (o_line_out & $past(i_wdata)) == 32'h0)
    else $error("drive clear write missed a line");
  AST_DRV_HOLD: assert property (!w_set && !w_clr && !w_dir |=> $stable(o_line_out))
    else $error("drive value changed without a write");
  AST_OE_READ: assert property (i_rd && i_addr == gpio_line_pkg::OFS_OUT_ENABLE_STATUS
    |=> o_rdata == ~$past(o_line_oe_n)) else $error("output status read wrong");
  AST_DRV_READ: assert property (i_rd && i_addr == gpio_line_pkg::OFS_DRIVE_STATUS
    |=> o_rdata == $past(o_line_out)) else $error("drive status read wrong");
  AST_IRQ_OFF: assert property (i_wr && i_addr == gpio_line_pkg::OFS_IRQ_DISABLE
    && i_wdata == 32'hFFFF_FFFF |=> !o_irq) else $error("interrupt high with all lines masked");

  COV_IRQ: cover property ($rose(o_irq));
  COV_OE: cover property (w_oe_on ##1 w_oe_off);
  COV_DIR: cover property (w_dir);
endmodule : gpio_line_checker

bind gpio_line_control_status gpio_line_checker #(.LINES(LINES)) u_checker (
  .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_line_in(i_line_in),
  .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n));

/* tb/gpio_pin_model.sv */
/*
  Model of the circuitry on the I/O lines: each pin shows the block's drive
  while its driver is on, else the level the outside circuit applies.
  Assumes the outside level is given per line by the bench.
*/
`timescale 1ns/1ps
module gpio_pin_model (
  // From the block
  input  wire logic [31:0] i_drive,
  input  wire logic [31:0] i_oe_n,
  // From the outside circuit
  input  wire logic [31:0] i_ext,
  // Resolved pins
  output logic      [31:0] o_pin
);
  // ==========================================================================
  // Pin resolution
  // The block wins where it drives, so a shorted line never shows as unknown.
  assign o_pin = (i_drive & ~i_oe_n) | (i_ext & i_oe_n);
endmodule : gpio_pin_model

/* tb/testbench.sv */
/*
  Self-checking bench of the line control block, with the pin model on its lines.
  Assumes the register offsets of the shared package and single-cycle accesses.
*/
`timescale 1ns/1ps
module testbench;
  // ==========================================================================
  // Signals
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [31:0] ext     = 32'h0;
  logic [31:0] rdata, line_out, oe_n, pins;
  logic        irq;
  int          n_errors    = 0;
  int          checks_done = 0;
  logic [7:0]  ofs [6] = '{8'h08, 8'h14, 8'h20, 8'h30, 8'h34, 8'h40};

  always #2.5 i_clock = ~i_clock;

  gpio_line_control_status #(.LINES(32)) DUT (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_line_in(pins), .o_line_out(line_out),
    .o_line_oe_n(oe_n));
  gpio_pin_model u_pins (.i_drive(line_out), .i_oe_n(oe_n), .i_ext(ext), .o_pin(pins));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clock);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clock);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_reg
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 20) begin
      @(posedge i_clock);
      k++;
    end
    chk({31'h0, irq}, 32'h1);
    if (irq !== 1'b1) wrap_up();
  endtask : wait_irq
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Sequence
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    foreach (ofs[i]) rd_reg(ofs[i], 32'h0);
    rd_reg(8'hFC, 32'h0);
    $display("test reset values done");
    wr_reg(8'h00, 32'hFFFF_0000);
    wr_reg(8'h04, 32'hF000_0000);
    wr_reg(8'h04, 32'h0);
    rd_reg(8'h08, 32'h0FFF_0000);
    chk(oe_n, 32'hF000_FFFF);
    $display("test output enable done");
    wr_reg(8'h18, 32'hA5A5_A5A5);
    wr_reg(8'h1C, 32'h0000_FFFF);
    wr_reg(8'h18, 32'h0);
    rd_reg(8'h20, 32'hA5A5_0000);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    rd_reg(8'h20, 32'hA5A5_0000);
    wr_reg(8'h38, 32'h0000_00FF);
    wr_reg(8'h20, 32'h0000_000F);
    rd_reg(8'h20, 32'hA5A5_000F);
    rd_reg(8'h40, 32'h0000_00FF);
    wr_reg(8'h3C, 32'h0000_000F);
    rd_reg(8'h40, 32'h0000_00F0);
    chk(line_out, 32'hA5A5_000F);
    $display("test drive value done");
    @(posedge i_clock);
    ext <= 32'h1234_5678;
    repeat (6) @(posedge i_clock);
    rd_reg(8'h24, (32'hA5A5_000F & 32'h0FFF_0000) | (32'h1234_5678 & 32'hF000_FFFF));
    rd_reg(8'h34, 32'h15A5_5678);
    $display("test pin level done");
    wr_reg(8'h0C, 32'h1);
    wr_reg(8'h0C, 32'h0);
    rd_reg(8'h14, 32'h1);
    @(posedge i_clock);
    ext <= ext ^ 32'h1;
    @(posedge i_clock);
    ext <= ext ^ 32'h1;
    repeat (6) @(posedge i_clock);
    rd_reg(8'h34, 32'h0);
    wr_reg(8'h10, 32'h1);
    rd_reg(8'h14, 32'h0);
    $display("test filter done");
    wr_reg(8'h28, 32'h2);
    wr_reg(8'h28, 32'h0);
    rd_reg(8'h30, 32'h2);
    chk({31'h0, irq}, 32'h0);
    @(posedge i_clock);
    ext <= ext ^ 32'h2;
    wait_irq();
    rd_reg(8'h34, 32'h2);
    chk({31'h0, irq}, 32'h0);
    rd_reg(8'h34, 32'h0);
    @(posedge i_clock);
    ext <= ext ^ 32'h4;
    wr_reg(8'h2C, 32'hFFFF_FFFF);
    repeat (6) @(posedge i_clock);
    chk({31'h0, irq}, 32'h0);
    rd_reg(8'h30, 32'h0);
    rd_reg(8'h34, 32'h4);
    @(posedge i_clock);
    ext <= ext ^ 32'h18;
    repeat (6) @(posedge i_clock);
    wr_reg(8'h44, 32'h0000_0008);
    rd_reg(8'h34, 32'h0000_0010);
    $display("test interrupt done");
    wrap_up();
  end
endmodule : testbench
